// ==== logic/acdr_map.svh ====
// Register indices, field positions and reset values of the converter block.
// Assumes byte address = index * 4 on a 32-bit AHB-Lite slave.
`ifndef ACDR_MAP_SVH
`define ACDR_MAP_SVH

// ==========================================================================
// Register indices
`define ACDR_IDX_RES_LO 8'hc2
`define ACDR_IDX_RES_HI 8'hc3
`define ACDR_IDX_CMP_LO 8'hce
`define ACDR_IDX_CMP_HI 8'hcf
`define ACDR_IDX_CTRL2 8'he2
`define ACDR_IDX_DLY_LO 8'he3
`define ACDR_IDX_DISC 8'hf6
`define ACDR_IDX_CTRL1 8'he1
`define ACDR_IDX_STAT 8'he8
`define ACDR_IDX_PWM 8'hd8

// ==========================================================================
// Field positions
`define ACDR_C2_BRK_EN 7
`define ACDR_C2_POL 6
`define ACDR_C2_CMP_EN 5
`define ACDR_C2_CMP_OUT 4
`define ACDR_C2_DLY8 0
`define ACDR_C1_EXT 1
`define ACDR_ST_DONE 7
`define ACDR_ST_BUSY 6
`define ACDR_PWM_RUN 7

// ==========================================================================
// Reset values
`define ACDR_RST_BYTE 8'h00
`define ACDR_RST_WORD 32'h0000_0000
`define ACDR_RST_DLY 9'h000
`define ACDR_RST_VAL12 12'h000

`endif

// ==== logic/acdr_pkg.sv ====
// Types shared by the converter control block.
// Assumes nothing beyond a SystemVerilog compiler.
package acdr_pkg;

  // ========================================================================
  // Sequencer phases
  typedef enum logic [1:0] {
    ACDR_IDLE = 2'b00,
    ACDR_DELAY = 2'b01,
    ACDR_CONVERT = 2'b10
  } acdr_phase_t;

  // ========================================================================
  // Analog core answer
  typedef struct packed {
    logic conv_done;
    logic [11:0] result;
  } acdr_core_t;

  // PWM unit side
  typedef struct packed {
    logic brake;
    logic pwm_run;
  } acdr_pwm_t;

  // ========================================================================
  // Whole block state
  typedef struct packed {
    acdr_phase_t phase;
    logic [8:0] dly_cnt;
    logic [11:0] result;
    logic [11:0] cmp_val;
    logic cmp_out;
    logic brk_en;
    logic pol;
    logic cmp_en;
    logic [8:0] dly;
    logic [7:0] disc;
    logic ext_sel;
    logic done;
    logic pwm_run;
    logic brake;
    logic start_pulse;
    logic [7:0] pin_out;
    logic ph_wr;
    logic ph_ok;
    logic [7:0] ph_idx;
    logic [31:0] hrdata;
  } acdr_state_t;

endpackage

// ==== logic/acdr_top.sv ====
// Converter control: result comparator with fault brake, trigger delay,
// split result and compare registers, digital input disconnect.
// Assumes an AHB-Lite master with single word transfers, an analog core
// that pulses conv_done with its result, and an ADC clock tick on hclk.
`timescale 1ns/1ps
`include "acdr_map.svh"

// Summary of operation
// - Compare output 1 at a conversion end with brake enable asserts brake, clears run.
// - Brake holds until software sets the PWM run bit again.
// - Polarity 0: output is 1 when result >= compare value.
// - Polarity 1: output is 1 when result < compare value.
// - Comparator works only while its enable bit is 1.
// - Compare output is read-only, updated at each conversion end while the comparator is enabled.
// - Disconnect bit 1 forces that pin's digital input to read 0.
// - Delay count is 9 bits, bit 8 lives in control two bit 0.
// - After an external trigger, wait out the delay, then convert.
// - Each unit of delay is one ADC clock cycle.
// - Delay applies only with external triggering enabled.
// - High result byte shows result bits 11 to 4.
// - Low result byte shows bits 3 to 0, upper nibble zero.
// - Compare high byte holds compare bits 11 to 4, read-write.
// - Compare low byte holds bits 3 to 0, upper nibble zero.
// - Done flag sets at completion, software clears, blocks new starts.
// - External mode starts by software or trigger, else software only.
// - Triggers ignored while busy until conversion completes.
module acdr_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire acdr_pkg::acdr_core_t core,
  output logic conv_start,
  input wire logic adc_tick,
  input wire logic ext_trigger,
  output acdr_pkg::acdr_pwm_t pwm,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out
);

  // ========================================================================
  // State
  acdr_pkg::acdr_state_t st;
  acdr_pkg::acdr_state_t next_st;

  logic acc;
  logic wr;
  logic [7:0] wd;
  logic done_evt;
  logic cmp_new;
  logic sw_start;
  logic trig_ok;

  // Address phase accepted
  assign acc = hsel & htrans[1] & hready;

  // Data phase write strobe and byte
  assign wr = st.ph_wr & st.ph_ok;
  assign wd = hwdata[7:0];

  // Conversion end and fresh compare value
  assign done_evt = (st.phase == acdr_pkg::ACDR_CONVERT) & core.conv_done;
  assign cmp_new = st.pol ? (core.result < st.cmp_val)
                          : (core.result >= st.cmp_val);

  // Start sources, blocked by a pending done flag
  assign sw_start = wr & (st.ph_idx == `ACDR_IDX_STAT) & wd[`ACDR_ST_BUSY]
                    & ~st.done;
  assign trig_ok = st.ext_sel & ext_trigger & ~st.done;

  // ========================================================================
  // Next state
  always_comb begin
    next_st = st;
    next_st.start_pulse = 1'b0;

    // Bus address phase capture
    next_st.ph_wr = acc & hwrite;
    next_st.ph_idx = haddr[9:2];
    next_st.ph_ok = acc && (haddr[31:10] == 22'h00_0000)
                    && (haddr[1:0] == 2'b00);
    next_st.hrdata = `ACDR_RST_WORD;
    if (acc && !hwrite && next_st.ph_ok) begin
      unique case (haddr[9:2])
        `ACDR_IDX_RES_LO: next_st.hrdata[3:0] = st.result[3:0];
        `ACDR_IDX_RES_HI: next_st.hrdata[7:0] = st.result[11:4];
        `ACDR_IDX_CMP_LO: next_st.hrdata[3:0] = st.cmp_val[3:0];
        `ACDR_IDX_CMP_HI: next_st.hrdata[7:0] = st.cmp_val[11:4];
        `ACDR_IDX_CTRL2: begin
          next_st.hrdata[`ACDR_C2_BRK_EN] = st.brk_en;
          next_st.hrdata[`ACDR_C2_POL] = st.pol;
          next_st.hrdata[`ACDR_C2_CMP_EN] = st.cmp_en;
          next_st.hrdata[`ACDR_C2_CMP_OUT] = st.cmp_out;
          next_st.hrdata[`ACDR_C2_DLY8] = st.dly[8];
        end
        `ACDR_IDX_DLY_LO: next_st.hrdata[7:0] = st.dly[7:0];
        `ACDR_IDX_DISC: next_st.hrdata[7:0] = st.disc;
        `ACDR_IDX_CTRL1: next_st.hrdata[`ACDR_C1_EXT] = st.ext_sel;
        `ACDR_IDX_STAT: begin
          next_st.hrdata[`ACDR_ST_DONE] = st.done;
          next_st.hrdata[`ACDR_ST_BUSY] =
            (st.phase != acdr_pkg::ACDR_IDLE);
        end
        `ACDR_IDX_PWM: next_st.hrdata[`ACDR_PWM_RUN] = st.pwm_run;
        default: next_st.hrdata = `ACDR_RST_WORD;
      endcase
    end

    // Register writes in the data phase
    if (wr) begin
      unique case (st.ph_idx)
        `ACDR_IDX_CMP_LO: next_st.cmp_val[3:0] = wd[3:0];
        `ACDR_IDX_CMP_HI: next_st.cmp_val[11:4] = wd;
        `ACDR_IDX_CTRL2: begin
          next_st.brk_en = wd[`ACDR_C2_BRK_EN];
          next_st.pol = wd[`ACDR_C2_POL];
          next_st.cmp_en = wd[`ACDR_C2_CMP_EN];
          next_st.dly[8] = wd[`ACDR_C2_DLY8];
        end
        `ACDR_IDX_DLY_LO: next_st.dly[7:0] = wd;
        `ACDR_IDX_DISC: next_st.disc = wd;
        `ACDR_IDX_CTRL1: next_st.ext_sel = wd[`ACDR_C1_EXT];
        `ACDR_IDX_STAT: begin
          if (!wd[`ACDR_ST_DONE]) begin
            next_st.done = 1'b0;
          end
        end
        `ACDR_IDX_PWM: begin
          next_st.pwm_run = wd[`ACDR_PWM_RUN];
          if (wd[`ACDR_PWM_RUN]) begin
            next_st.brake = 1'b0;
          end
        end
        default: next_st.pwm_run = st.pwm_run;
      endcase
    end

    // Conversion sequencer
    unique case (st.phase)
      acdr_pkg::ACDR_IDLE: begin
        if (sw_start) begin
          next_st.phase = acdr_pkg::ACDR_CONVERT;
          next_st.start_pulse = 1'b1;
        end else if (trig_ok && st.dly == `ACDR_RST_DLY) begin
          next_st.phase = acdr_pkg::ACDR_CONVERT;
          next_st.start_pulse = 1'b1;
        end else if (trig_ok) begin
          next_st.phase = acdr_pkg::ACDR_DELAY;
          next_st.dly_cnt = st.dly;
        end
      end
      acdr_pkg::ACDR_DELAY: begin
        if (sw_start) begin
          next_st.phase = acdr_pkg::ACDR_CONVERT;
          next_st.start_pulse = 1'b1;
        end else if (adc_tick) begin
          next_st.dly_cnt = st.dly_cnt - 9'h001;
          if (st.dly_cnt == 9'h001) begin
            next_st.phase = acdr_pkg::ACDR_CONVERT;
            next_st.start_pulse = 1'b1;
          end
        end
      end
      acdr_pkg::ACDR_CONVERT: begin
        // Triggers and starts ignored here
        if (core.conv_done) begin
          next_st.phase = acdr_pkg::ACDR_IDLE;
        end
      end
      default: next_st.phase = acdr_pkg::ACDR_IDLE;
    endcase

    // Completion: result, flag and comparator, set beats clear
    if (done_evt) begin
      next_st.result = core.result;
      next_st.done = 1'b1;
      if (st.cmp_en) begin
        next_st.cmp_out = cmp_new;
        if (st.brk_en && cmp_new) begin
          next_st.brake = 1'b1;
          next_st.pwm_run = 1'b0;
        end
      end
    end

    // Digital input gating
    next_st.pin_out = pin_in & ~st.disc;
  end

  // ========================================================================
  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st.phase <= acdr_pkg::ACDR_IDLE;
      st.dly_cnt <= `ACDR_RST_DLY;
      st.result <= `ACDR_RST_VAL12;
      st.cmp_val <= `ACDR_RST_VAL12;
      st.cmp_out <= 1'b0;
      st.brk_en <= 1'b0;
      st.pol <= 1'b0;
      st.cmp_en <= 1'b0;
      st.dly <= `ACDR_RST_DLY;
      st.disc <= `ACDR_RST_BYTE;
      st.ext_sel <= 1'b0;
      st.done <= 1'b0;
      st.pwm_run <= 1'b0;
      st.brake <= 1'b0;
      st.start_pulse <= 1'b0;
      st.pin_out <= `ACDR_RST_BYTE;
      st.ph_wr <= 1'b0;
      st.ph_ok <= 1'b0;
      st.ph_idx <= `ACDR_RST_BYTE;
      st.hrdata <= `ACDR_RST_WORD;
    end else begin
      st <= next_st;
    end
  end

  // ========================================================================
  // Outputs
  assign hrdata = st.hrdata;
  assign hreadyout = 1'b1; // Zero wait states
  assign hresp = 1'b0; // Always OKAY
  assign conv_start = st.start_pulse;
  assign pwm.brake = st.brake;
  assign pwm.pwm_run = st.pwm_run;
  assign pin_out = st.pin_out;

  // ========================================================================
  // Checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Comparator enabled completion
  sequence s_cmp_done;
    done_evt && st.cmp_en;
  endsequence

  // Accepted external trigger with zero delay
  sequence s_trig_now;
    st.phase == acdr_pkg::ACDR_IDLE && trig_ok && !sw_start
      && st.dly == `ACDR_RST_DLY;
  endsequence

  // Accepted external trigger with nonzero delay
  sequence s_trig_wait;
    st.phase == acdr_pkg::ACDR_IDLE && trig_ok && !sw_start
      && st.dly != `ACDR_RST_DLY;
  endsequence

  a_cmp_ge_pol: assert property (
    s_cmp_done ##0 !st.pol |=>
      st.cmp_out == ($past(core.result) >= $past(st.cmp_val)))
    else $error("compare output wrong for polarity 0");

  a_cmp_lt_pol: assert property (
    s_cmp_done ##0 st.pol |=>
      st.cmp_out == ($past(core.result) < $past(st.cmp_val)))
    else $error("compare output wrong for polarity 1");

  a_cmp_disabled_hold: assert property (
    done_evt && !st.cmp_en |=> $stable(st.cmp_out) && !$rose(st.brake))
    else $error("disabled comparator changed state");

  a_cmp_update_only: assert property (
    $changed(st.cmp_out) |-> $past(done_evt) && $past(st.cmp_en))
    else $error("compare output changed without completion");

  a_brake_raise: assert property (
    s_cmp_done ##0 st.brk_en && cmp_new |=> pwm.brake && !pwm.pwm_run)
    else $error("brake not asserted on compare");

  a_brake_hold: assert property (
    pwm.brake && !(wr && st.ph_idx == `ACDR_IDX_PWM && wd[`ACDR_PWM_RUN])
      |=> pwm.brake)
    else $error("brake released without run bit");

  a_brake_cause: assert property (
    $rose(pwm.brake) |-> $past(st.cmp_en) && $past(st.brk_en))
    else $error("brake raised with comparator off");

  a_pin_gated: assert property (
    ##1 (pin_out & $past(st.disc)) == 8'h00)
    else $error("disconnected pin reads one");

  a_trig_nodelay: assert property (
    s_trig_now |=> conv_start)
    else $error("zero delay trigger did not start");

  a_trig_delayed: assert property (
    s_trig_wait |=> !conv_start && st.phase == acdr_pkg::ACDR_DELAY
      && st.dly_cnt == $past(st.dly))
    else $error("delay not loaded on trigger");

  a_delay_end: assert property (
    st.phase == acdr_pkg::ACDR_DELAY && adc_tick
      && st.dly_cnt == 9'h001 |=> conv_start)
    else $error("delay end did not start");

  a_soft_only: assert property (
    st.phase == acdr_pkg::ACDR_IDLE && !st.ext_sel && !sw_start
      |=> !conv_start)
    else $error("start without software in software mode");

  a_busy_ignore: assert property (
    st.phase == acdr_pkg::ACDR_CONVERT |=> !conv_start)
    else $error("start while converting");

  a_done_set: assert property (
    done_evt |=> st.done ##0 st.phase == acdr_pkg::ACDR_IDLE)
    else $error("done flag not set at completion");

  a_done_blocks: assert property (
    st.done && st.phase == acdr_pkg::ACDR_IDLE |=> !conv_start)
    else $error("start while done flag set");

  a_res_read: assert property (
    acc && !hwrite && haddr == {22'h00_0000, `ACDR_IDX_RES_HI, 2'b00}
      |=> hrdata == {24'h00_0000, $past(st.result[11:4])})
    else $error("high result byte read wrong");

  // Register read paths and read-only result
  a_res_lo_read: assert property (
    acc && !hwrite && haddr == {22'h00_0000, `ACDR_IDX_RES_LO, 2'b00}
      |=> hrdata == {28'h000_0000, $past(st.result[3:0])})
    else $error("low result nibble read wrong");

  a_cmp_hi_read: assert property (
    acc && !hwrite && haddr == {22'h00_0000, `ACDR_IDX_CMP_HI, 2'b00}
      |=> hrdata == {24'h00_0000, $past(st.cmp_val[11:4])})
    else $error("compare high byte read wrong");

  a_cmp_lo_read: assert property (
    acc && !hwrite && haddr == {22'h00_0000, `ACDR_IDX_CMP_LO, 2'b00}
      |=> hrdata == {28'h000_0000, $past(st.cmp_val[3:0])})
    else $error("compare low nibble read wrong");

  a_res_read_only: assert property (
    wr && (st.ph_idx == `ACDR_IDX_RES_HI || st.ph_idx == `ACDR_IDX_RES_LO)
      && !done_evt |=> $stable(st.result))
    else $error("result changed by a bus write");

  // Delay count composition
  a_dly_high_bit: assert property (
    wr && st.ph_idx == `ACDR_IDX_CTRL2
      |=> st.dly[8] == $past(wd[`ACDR_C2_DLY8]))
    else $error("delay bit eight not taken");

  a_dly_low_byte: assert property (
    wr && st.ph_idx == `ACDR_IDX_DLY_LO |=> st.dly[7:0] == $past(wd))
    else $error("delay low byte not taken");

  // Brake release and start sources
  a_brake_release: assert property (
    wr && st.ph_idx == `ACDR_IDX_PWM && wd[`ACDR_PWM_RUN]
      && !(done_evt && st.cmp_en && st.brk_en && cmp_new)
      |=> !pwm.brake && pwm.pwm_run)
    else $error("run bit did not release brake");

  a_soft_start: assert property (
    sw_start && st.phase != acdr_pkg::ACDR_CONVERT |=> conv_start)
    else $error("software start not honoured");

  a_delay_quiet: assert property (
    st.phase == acdr_pkg::ACDR_DELAY && !sw_start
      && !(adc_tick && st.dly_cnt == 9'h001) |=> !conv_start)
    else $error("start before delay ran out");

endmodule // acdr_top

// ==== test/acdr_core_model.sv ====
// Behavioural analog converter core and ADC clock tick source.
// Assumes conv_start pulses for one cycle and the bench sets next_result.
`timescale 1ns/1ps

module acdr_core_model #(
  parameter logic [3:0] LAT = 4'h5
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic conv_start,
  input wire logic [11:0] next_result,
  output acdr_pkg::acdr_core_t core,
  output logic adc_tick
);
  // ========================================================================
  // Conversion timing and tick divider
  logic [3:0] busy_cnt;
  logic [1:0] div;
  logic [11:0] last;

  // Tick every third cycle; result bus shows junk outside the done pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_cnt <= 4'h0;
      div <= 2'h0;
      adc_tick <= 1'b0;
      core <= '0;
      last <= 12'h000;
    end else begin
      div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
      adc_tick <= (div == 2'h2);
      core.conv_done <= 1'b0;
      core.result <= ~last;
      if (conv_start) begin
        busy_cnt <= LAT;
      end else if (busy_cnt == 4'h1) begin
        core.conv_done <= 1'b1;
        core.result <= next_result;
        last <= next_result;
        busy_cnt <= 4'h0;
      end else if (busy_cnt != 4'h0) begin
        busy_cnt <= busy_cnt - 4'h1;
      end
    end
  end
endmodule // acdr_core_model

// ==== test/tb_adc_compare_delay_result.sv ====
// Self-checking bench of the converter control block over AHB-Lite.
// Assumes acdr_top, its package and map header, and acdr_core_model.
`timescale 1ns/1ps
`include "acdr_map.svh"

module tb_adc_compare_delay_result;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic conv_start, adc_tick, ext_trigger;
  logic [7:0] pin_in, pin_out;
  logic [11:0] next_result;
  acdr_pkg::acdr_core_t core;
  acdr_pkg::acdr_pwm_t pwm;
  int mismatches, num_checks, starts, ticks, i, k, n0;
  logic [7:0] regs [7] = '{8'hc2, 8'hc3, 8'hce, 8'hcf, 8'he2, 8'he3, 8'hf6};
  logic [11:0] rt [4] = '{12'h800, 12'h7ff, 12'h7ff, 12'h800};
  logic pt [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
  logic et [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

  // ========================================================================
  // Clock, design and partner
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  acdr_top i_acdr_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .core(core),
    .conv_start(conv_start), .adc_tick(adc_tick),
    .ext_trigger(ext_trigger), .pwm(pwm), .pin_in(pin_in),
    .pin_out(pin_out));

  acdr_core_model i_acdr_core_model (.hclk(hclk), .hresetn(hresetn),
    .conv_start(conv_start), .next_result(next_result), .core(core),
    .adc_tick(adc_tick));

  // Count conversion starts seen at the ports
  always @(posedge hclk) begin
    if (conv_start === 1'b1) starts++;
  end

  // ========================================================================
  // Tasks
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One single AHB-Lite transfer; read data lands in rdata
  task xfer(input logic [7:0] idx, input logic w, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdata = hrdata;
  endtask

  task wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(idx, 1'b1, d);
  endtask

  task rd(input logic [7:0] idx);
    xfer(idx, 1'b0, 8'h00);
  endtask

  // Poll the status register until the done flag shows
  task wait_done;
    int j;
    j = 0;
    rdata = 32'h0000_0000;
    while (rdata[7] !== 1'b1 && j < 40) begin
      rd(`ACDR_IDX_STAT);
      j++;
    end
    chk(rdata[7], 32'h1);
  endtask

  // Software-started conversion with a chosen result
  task convert(input logic [11:0] r);
    next_result = r;
    wr(`ACDR_IDX_STAT, 8'h00);
    wr(`ACDR_IDX_STAT, 8'h40);
    wait_done();
  endtask

  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Watchdog cuts a hang short
  initial begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    give_verdict();
  end

  // ========================================================================
  // Tests
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    ext_trigger = 1'b0;
    pin_in = 8'h00;
    next_result = 12'h000;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values and an unmapped place
    for (k = 0; k < 7; k++) begin
      rd(regs[k]);
      chk(rdata, 32'h0000_0000);
    end
    wr(8'h10, 8'hff);
    rd(8'h10);
    chk(rdata, 32'h0000_0000);
    // Compare bytes, control two access kinds, delay bit 8
    wr(`ACDR_IDX_CMP_HI, 8'ha5);
    wr(`ACDR_IDX_CMP_LO, 8'hff);
    rd(`ACDR_IDX_CMP_HI);
    chk(rdata, 32'h0000_00a5);
    rd(`ACDR_IDX_CMP_LO);
    chk(rdata, 32'h0000_000f);
    wr(`ACDR_IDX_CTRL2, 8'hff);
    rd(`ACDR_IDX_CTRL2);
    chk(rdata, 32'h0000_00e1);
    // Disconnect masks the pin inputs
    pin_in <= 8'hff;
    wr(`ACDR_IDX_DISC, 8'h5a);
    repeat (2) @(posedge hclk);
    chk(pin_out, 32'h0000_00a5);
    pin_in <= 8'h3c;
    repeat (2) @(posedge hclk);
    chk(pin_out, 32'h0000_0024);
    // Result split and read-only
    wr(`ACDR_IDX_CTRL2, 8'h00);
    convert(12'hab7);
    wr(`ACDR_IDX_RES_HI, 8'hff);
    rd(`ACDR_IDX_RES_HI);
    chk(rdata, 32'h0000_00ab);
    rd(`ACDR_IDX_RES_LO);
    chk(rdata, 32'h0000_0007);
    // Comparator at the boundary in both polarities
    wr(`ACDR_IDX_CMP_HI, 8'h80);
    wr(`ACDR_IDX_CMP_LO, 8'h00);
    for (k = 0; k < 4; k++) begin
      wr(`ACDR_IDX_CTRL2, {1'b0, pt[k], 6'h20});
      convert(rt[k]);
      rd(`ACDR_IDX_CTRL2);
      chk(rdata, {24'h0, 1'b0, pt[k], 1'b1, et[k], 4'h0});
    end
    // Disabled comparator holds its output and raises no brake
    wr(`ACDR_IDX_CTRL2, 8'hc0);
    convert(12'h000);
    rd(`ACDR_IDX_CTRL2);
    chk(rdata, 32'h0000_00c0);
    chk(pwm.brake, 32'h0);
    // Brake on compare, held until run is set again
    wr(`ACDR_IDX_PWM, 8'h80);
    @(posedge hclk);
    chk(pwm.pwm_run, 32'h1);
    wr(`ACDR_IDX_CTRL2, 8'ha0);
    convert(12'hfff);
    chk({pwm.brake, pwm.pwm_run}, 32'h2);
    repeat (20) @(posedge hclk);
    chk({pwm.brake, pwm.pwm_run}, 32'h2);
    wr(`ACDR_IDX_PWM, 8'h80);
    @(posedge hclk);
    chk({pwm.brake, pwm.pwm_run}, 32'h1);
    // Nine-bit delay of 258 ticks after an external trigger
    wr(`ACDR_IDX_PWM, 8'h00);
    wr(`ACDR_IDX_CTRL2, 8'h01);
    wr(`ACDR_IDX_DLY_LO, 8'h02);
    rd(`ACDR_IDX_CTRL2);
    chk(rdata, 32'h0000_0011);
    wr(`ACDR_IDX_CTRL1, 8'h02);
    wr(`ACDR_IDX_STAT, 8'h00);
    n0 = starts;
    @(posedge hclk) ext_trigger <= 1'b1;
    @(posedge hclk) ext_trigger <= 1'b0;
    ticks = 0;
    i = 0;
    // A second trigger in mid-delay must be ignored
    do begin
      @(posedge hclk);
      if (conv_start !== 1'b1) ticks += adc_tick;
      ext_trigger <= (i == 20);
      i++;
    end while (conv_start !== 1'b1 && i < 3000);
    chk(ticks, 32'd258);
    wait_done();
    // Trigger while done is set starts nothing
    @(posedge hclk) ext_trigger <= 1'b1;
    @(posedge hclk) ext_trigger <= 1'b0;
    repeat (30) @(posedge hclk);
    chk(starts, n0 + 1);
    // Software starts only; trigger ignored, no delay applied
    wr(`ACDR_IDX_CTRL1, 8'h00);
    wr(`ACDR_IDX_STAT, 8'h00);
    @(posedge hclk) ext_trigger <= 1'b1;
    @(posedge hclk) ext_trigger <= 1'b0;
    repeat (30) @(posedge hclk);
    chk(starts, n0 + 1);
    wr(`ACDR_IDX_STAT, 8'h40);
    repeat (3) @(posedge hclk);
    chk(starts, n0 + 2);
    wait_done();
    // Zero delay external trigger starts on the next cycle
    wr(`ACDR_IDX_CTRL1, 8'h02);
    wr(`ACDR_IDX_DLY_LO, 8'h00);
    wr(`ACDR_IDX_CTRL2, 8'h00);
    wr(`ACDR_IDX_STAT, 8'h00);
    @(posedge hclk) ext_trigger <= 1'b1;
    @(posedge hclk) ext_trigger <= 1'b0;
    repeat (2) @(posedge hclk);
    chk(starts, n0 + 3);
    wait_done();
    give_verdict();
  end
endmodule // tb_adc_compare_delay_result
